// ### logic/flash_id_defs.vh
// Constants for the power-down and identification instruction handler
// Notes on behaviour
// - Opcode B9h shifted in under low chip select requests deep power-down.
// - Power-down runs only if chip select rises right after the eighth bit.
// - Power-down state is reached within the entry delay after chip select rises.
// - While powered down only ABh is recognised; all else is ignored.
// - After reset the device is in normal standby, never powered down.
// - ABh then chip select high wakes the device after wake_delay.
// - ABh plus 3 dummy bytes returns the device code MSB first on falling edges.
// - The device code repeats until chip select rises.
// - ABh code read out of power-down wakes after wake_with_code_delay.
// - ABh arriving while busy is ignored and leaves the cycle untouched.
// - 90h plus zero 24-bit address returns manufacturer then device code.
// - 90h, 92h and 94h reads alternate manufacturer and device code until chip select rises.
// - 92h takes address two bits per clock and returns codes two bits per clock.
// - 94h takes address four bits per clock and returns codes four bits per clock.
// - 4Bh plus four dummy bytes returns the 64-bit unique number.
// - 9Fh returns manufacturer, memory_type_byte and capacity_byte MSB first.
// - 5Ah, 24-bit address, eight dummy clocks; table data starts on 40th falling edge.
// - Upper sixteen address bits are zero; low eight select the table start byte.
// - Busy reads 1 while a self-timed cycle runs and 0 once it is finished.
`ifndef FLASH_ID_DEFS_VH
`define FLASH_ID_DEFS_VH

// ------------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------------
`define OP_POWER_DOWN   8'hB9
`define OP_RELEASE_ID   8'hAB
`define OP_MFR_DEV      8'h90
`define OP_MFR_DEV_DUAL 8'h92
`define OP_MFR_DEV_QUAD 8'h94
`define OP_UNIQUE_ID    8'h4B
`define OP_IDENTITY     8'h9F
`define OP_TABLE_READ   8'h5A

// ------------------------------------------------------------------
// Identity values (all arbitrary neutral values)
// ------------------------------------------------------------------
`define MFR_CODE        8'hA5
`define DEVICE_CODE     8'h11
`define MEMORY_TYPE     8'h60
`define CAPACITY        8'h12
`define UNIQUE_NUMBER   64'h0123_4567_89AB_CDEF
`define TABLE_SIG0      8'h53
`define TABLE_SIG1      8'h46
`define TABLE_SIG2      8'h44
`define TABLE_SIG3      8'h50
`define TABLE_FILL      8'hFF

// ------------------------------------------------------------------
// Preamble clocks after the opcode, and address clocks within it
// ------------------------------------------------------------------
`define PRE_RELEASE_ID  6'd24
`define PRE_MFR_DEV     6'd24
`define PRE_DUAL        6'd16
`define PRE_QUAD        6'd12
`define PRE_UNIQUE      6'd32
`define PRE_TABLE       6'd32
`define ADDR_SINGLE     5'd24
`define ADDR_DUAL       5'd12
`define ADDR_QUAD       5'd6

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CLK_PERIOD_NS   5
`define PD_ENTRY_NS     3000
`define WAKE_NS         3000
`define WAKE_CODE_NS    1800
`define PD_ENTRY_CYC    (`PD_ENTRY_NS / `CLK_PERIOD_NS)
`define WAKE_CYC        (`WAKE_NS / `CLK_PERIOD_NS)
`define WAKE_CODE_CYC   (`WAKE_CODE_NS / `CLK_PERIOD_NS)
`define PIN_LAT_CYC     4

`endif

// ### logic/byte_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk,
   input  wire             reset,
   input  wire             clear,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_q];

   always @(posedge clk) begin
      if (push)
         mem[wr_q] <= in_data;
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else if (clear) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
      end
   end

endmodule // byte_fifo

// ### logic/flash_pd_id.v
// Power-down and identification instruction handler of a serial flash
`timescale 1ns/10ps
`include "flash_id_defs.vh"
module flash_pd_id (
   input  wire       core_clk,
   input  wire       reset,
   input  wire       sclk_pin,
   input  wire       cs_n_pin,
   input  wire [3:0] io_in,
   input  wire       cycle_busy,
   output reg  [3:0] io_out,
   output reg  [3:0] io_oe,
   output reg        power_down,
   output reg        busy
);

   // ------------------------------------------------------------------
   // Local constants
   // ------------------------------------------------------------------
   localparam [1:0]  ST_OPC  = 2'h0;
   localparam [1:0]  ST_PRE  = 2'h1;
   localparam [1:0]  ST_DATA = 2'h2;
   localparam [1:0]  ST_IGN  = 2'h3;
   localparam [1:0]  W1      = 2'h0;
   localparam [1:0]  W2      = 2'h1;
   localparam [1:0]  W4      = 2'h2;
   // Sync, edge and output stages add cycles of their own, so the counts are
   // shortened to keep the whole delay seen at the pins within the limit
   localparam [31:0] PD_FULL       = `PD_ENTRY_CYC - `PIN_LAT_CYC;
   localparam [31:0] WAKE_FULL     = `WAKE_CYC - `PIN_LAT_CYC;
   localparam [31:0] WCODE_FULL    = `WAKE_CODE_CYC - `PIN_LAT_CYC;
   localparam [11:0] PD_CYC        = PD_FULL[11:0];
   localparam [11:0] WAKE_CYC      = WAKE_FULL[11:0];
   localparam [11:0] WAKE_CODE_CYC = WCODE_FULL[11:0];

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   // {known, preamble clocks, address clocks, lane width}
   function [13:0] cmd_info;
      input [7:0] op;
      begin
         case (op)
            `OP_RELEASE_ID:   cmd_info = {1'b1, `PRE_RELEASE_ID, 5'd0, W1};
            `OP_MFR_DEV:      cmd_info = {1'b1, `PRE_MFR_DEV, `ADDR_SINGLE, W1};
            `OP_MFR_DEV_DUAL: cmd_info = {1'b1, `PRE_DUAL, `ADDR_DUAL, W2};
            `OP_MFR_DEV_QUAD: cmd_info = {1'b1, `PRE_QUAD, `ADDR_QUAD, W4};
            `OP_UNIQUE_ID:    cmd_info = {1'b1, `PRE_UNIQUE, 5'd0, W1};
            `OP_IDENTITY:     cmd_info = {1'b1, 6'd0, 5'd0, W1};
            `OP_TABLE_READ:   cmd_info = {1'b1, `PRE_TABLE, `ADDR_SINGLE, W1};
            default:          cmd_info = 14'h0000;
         endcase
      end
   endfunction

   function [7:0] table_byte;
      input [7:0] a;
      begin
         case (a)
            8'h00:   table_byte = `TABLE_SIG0;
            8'h01:   table_byte = `TABLE_SIG1;
            8'h02:   table_byte = `TABLE_SIG2;
            8'h03:   table_byte = `TABLE_SIG3;
            default: table_byte = `TABLE_FILL;
         endcase
      end
   endfunction

   function [7:0] out_byte;
      input [7:0] op;
      input [7:0] idx;
      reg   [63:0] uid;
      begin
         uid = `UNIQUE_NUMBER;
         case (op)
            `OP_RELEASE_ID:
               out_byte = `DEVICE_CODE;
            `OP_MFR_DEV, `OP_MFR_DEV_DUAL, `OP_MFR_DEV_QUAD:
               out_byte = idx[0] ? `DEVICE_CODE : `MFR_CODE;
            `OP_UNIQUE_ID:
               out_byte = uid[8'd63 - {idx[2:0], 3'b000} -: 8];
            `OP_IDENTITY:
               out_byte = (idx[1:0] == 2'd0) ? `MFR_CODE :
                          (idx[1:0] == 2'd1) ? `MEMORY_TYPE : `CAPACITY;
            `OP_TABLE_READ:
               out_byte = table_byte(idx);
            default:
               out_byte = `TABLE_FILL;
         endcase
      end
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------------
   reg       sclk_s1_q, sclk_s2_q, sclk_s3_q;
   reg       cs_s1_q, cs_s2_q, cs_s3_q;
   reg [3:0] io_s1_q, io_s2_q;

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         cs_s1_q   <= 1'b1;
         cs_s2_q   <= 1'b1;
         cs_s3_q   <= 1'b1;
         io_s1_q   <= 4'h0;
         io_s2_q   <= 4'h0;
      end else begin
         sclk_s1_q <= sclk_pin;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         cs_s1_q   <= cs_n_pin;
         cs_s2_q   <= cs_s1_q;
         cs_s3_q   <= cs_s2_q;
         io_s1_q   <= io_in;
         io_s2_q   <= io_s1_q;
      end
   end

   wire cs_low    = ~cs_s2_q;
   wire cs_rise   = cs_s2_q & ~cs_s3_q;
   wire sclk_rise = sclk_s2_q & ~sclk_s3_q & cs_low;
   wire sclk_fall = ~sclk_s2_q & sclk_s3_q & cs_low;

   // ------------------------------------------------------------------
   // Instruction state
   // ------------------------------------------------------------------
   reg [1:0]  st_q;
   reg [7:0]  op_q;
   reg [2:0]  bitc_q;
   reg [5:0]  pre_q;
   reg [4:0]  addrc_q;
   reg [1:0]  wid_q;
   reg [23:0] addr_q;
   reg [7:0]  idx_q;
   reg        op_ok_q;
   reg        extra_q;
   reg        acc_q;
   reg        pd_q;
   reg [11:0] tmr_q;
   reg        tmr_wake_q;

   wire [7:0]  op_next = {op_q[6:0], io_s2_q[0]};
   wire [13:0] info    = cmd_info(op_next);
   wire        tmr_run = (tmr_q != 12'h000);
   // While a delay runs nothing is accepted; a busy cycle blocks these reads
   wire        allowed = ~tmr_run & ~cycle_busy &
                         (~pd_q | (op_next == `OP_RELEASE_ID));
   reg  [23:0] addr_n;

   always @* begin
      case (wid_q)
         W2:      addr_n = {addr_q[21:0], io_s2_q[1:0]};
         W4:      addr_n = {addr_q[19:0], io_s2_q[3:0]};
         default: addr_n = {addr_q[22:0], io_s2_q[0]};
      endcase
      if (addrc_q == 5'd0)
         addr_n = addr_q;
   end

   // ------------------------------------------------------------------
   // FIFO between byte producer and output shifter
   // ------------------------------------------------------------------
   wire       f_in_ready;
   wire       f_out_valid;
   wire [7:0] f_out_data;
   wire       f_push = (st_q == ST_DATA) & cs_low & f_in_ready;
   reg        f_pop;

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (8),
      .AW    (3)
   ) u_fifo (
      .clk       (core_clk),
      .reset     (reset),
      .clear     (~cs_low),
      .in_valid  ((st_q == ST_DATA) & cs_low),
      .in_ready  (f_in_ready),
      .in_data   (out_byte(op_q, idx_q)),
      .out_valid (f_out_valid),
      .out_ready (f_pop),
      .out_data  (f_out_data)
   );

   // ------------------------------------------------------------------
   // Command sequencing
   // ------------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q    <= ST_OPC;
         op_q    <= 8'h00;
         bitc_q  <= 3'd0;
         pre_q   <= 6'd0;
         addrc_q <= 5'd0;
         wid_q   <= W1;
         addr_q  <= 24'h000000;
         idx_q   <= 8'h00;
         op_ok_q <= 1'b0;
         extra_q <= 1'b0;
         acc_q   <= 1'b0;
      end else if (~cs_low) begin
         st_q    <= ST_OPC;
         bitc_q  <= 3'd0;
         op_ok_q <= 1'b0;
         extra_q <= 1'b0;
         acc_q   <= 1'b0;
      end else begin
         if (f_push) begin
            if (op_q == `OP_IDENTITY && idx_q == 8'd2)
               idx_q <= 8'h00;
            else
               idx_q <= idx_q + 8'h01;
         end
         if (sclk_rise) begin
            case (st_q)
               ST_OPC: begin
                  op_q   <= op_next;
                  bitc_q <= bitc_q + 3'd1;
                  if (bitc_q == 3'd7) begin
                     op_ok_q <= 1'b1;
                     acc_q   <= allowed;
                     pre_q   <= info[12:7];
                     addrc_q <= info[6:2];
                     wid_q   <= info[1:0];
                     addr_q  <= 24'h000000;
                     idx_q   <= 8'h00;
                     if (~allowed | ~info[13])
                        st_q <= ST_IGN;
                     else if (info[12:7] == 6'd0)
                        st_q <= ST_DATA;
                     else
                        st_q <= ST_PRE;
                  end
               end
               ST_PRE: begin
                  extra_q <= 1'b1;
                  addr_q  <= addr_n;
                  if (addrc_q != 5'd0)
                     addrc_q <= addrc_q - 5'd1;
                  pre_q <= pre_q - 6'd1;
                  if (pre_q == 6'd1) begin
                     st_q <= ST_DATA;
                     if (op_q == `OP_TABLE_READ)
                        idx_q <= addr_n[7:0];
                     else if (op_q != `OP_UNIQUE_ID)
                        idx_q <= {7'd0, addr_n[0]};
                  end
               end
               default:
                  extra_q <= 1'b1;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Power-down entry and release
   // ------------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pd_q       <= 1'b0;
         tmr_q      <= 12'h000;
         tmr_wake_q <= 1'b0;
      end else if (tmr_run) begin
         tmr_q <= tmr_q - 12'h001;
         if (tmr_q == 12'h001)
            pd_q <= ~tmr_wake_q;
      end else if (cs_rise & acc_q & op_ok_q) begin
         if (op_q == `OP_POWER_DOWN && ~extra_q && ~pd_q) begin
            tmr_q      <= PD_CYC;
            tmr_wake_q <= 1'b0;
         end else if (op_q == `OP_RELEASE_ID && pd_q) begin
            tmr_wake_q <= 1'b1;
            // A read of the code takes the shorter recovery
            tmr_q      <= extra_q ? WAKE_CODE_CYC : WAKE_CYC;
         end
      end
   end

   // ------------------------------------------------------------------
   // Output shifter, bits change on falling clock edges
   // ------------------------------------------------------------------
   reg [7:0] sh_q;
   reg [3:0] left_q;
   reg [7:0] cur;
   reg [3:0] step;
   reg       shift_now;
   reg [3:0] lanes;
   reg [3:0] oe_lanes;

   always @* begin
      cur       = (left_q == 4'd0) ? f_out_data : sh_q;
      shift_now = sclk_fall & (st_q == ST_DATA) &
                  ((left_q != 4'd0) | f_out_valid);
      f_pop     = shift_now & (left_q == 4'd0);
      case (wid_q)
         W2: begin
            step     = 4'd2;
            lanes    = {2'b00, cur[7:6]};
            oe_lanes = 4'b0011;
         end
         W4: begin
            step     = 4'd4;
            lanes    = cur[7:4];
            oe_lanes = 4'b1111;
         end
         default: begin
            step     = 4'd1;
            lanes    = {2'b00, cur[7], 1'b0};
            oe_lanes = 4'b0010;
         end
      endcase
   end

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sh_q   <= 8'h00;
         left_q <= 4'd0;
         io_out <= 4'h0;
         io_oe  <= 4'h0;
      end else if (~cs_low) begin
         left_q <= 4'd0;
         io_oe  <= 4'h0;
      end else if (shift_now) begin
         io_out <= lanes;
         io_oe  <= oe_lanes;
         sh_q   <= cur << step;
         left_q <= ((left_q == 4'd0) ? 4'd8 : left_q) - step;
      end
   end

   // ------------------------------------------------------------------
   // Status outputs
   // ------------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         power_down <= 1'b0;
         busy       <= 1'b0;
      end else begin
         power_down <= pd_q;
         busy       <= cycle_busy;
      end
   end

endmodule // flash_pd_id

// ### verif/spi_host_model.sv
// SPI host model: drives chip select, serial clock and data lanes toward the flash
`timescale 1ns/10ps
module spi_host_model (
   input  wire       core_clk,
   input  wire [3:0] dev_io,
   output reg        sclk,
   output reg        cs_n,
   output reg  [3:0] io
);
   // 16 core cycles make the 80 ns half period of a 160 ns link clock
   localparam HALF = 16;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io   = 4'h0;
   end

   // ------------------------------------------------------------------
   // Frame primitives, all changes on the falling core clock edge
   // ------------------------------------------------------------------
   task open_frame;
      begin
         @(negedge core_clk) cs_n = 1'b0;
         repeat (HALF) @(negedge core_clk);
      end
   endtask

   // Lanes change while the link clock is low and hold across its rise
   task pulse(input [3:0] d, output [3:0] q);
      begin
         io = d;
         repeat (HALF) @(negedge core_clk);
         q = dev_io;
         sclk = 1'b1;
         repeat (HALF) @(negedge core_clk);
         sclk = 1'b0;
      end
   endtask

   // Chip select rises half a link period after the last fall; clock stays low between frames
   task close_frame;
      begin
         repeat (HALF) @(negedge core_clk);
         cs_n = 1'b1;
         io   = ~io;
      end
   endtask
endmodule // spi_host_model

// ### verif/flash_pd_id_monitor.sv
// Concurrent checks on the ports of the power-down and identification handler
`timescale 1ns/10ps
module flash_pd_id_monitor (
   input wire       core_clk,
   input wire       reset,
   input wire       sclk_pin,
   input wire       cs_n_pin,
   input wire [3:0] io_in,
   input wire       cycle_busy,
   input wire [3:0] io_out,
   input wire [3:0] io_oe,
   input wire       power_down,
   input wire       busy
);
   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   busy_set_a: assert property (cycle_busy [*2] |-> busy)
      else $error("busy low while a cycle runs");
   busy_clear_a: assert property (!cycle_busy [*2] |-> !busy)
      else $error("busy high after the cycle ended");
   busy_freeze_a: assert property (busy |=> $stable(power_down))
      else $error("power state changed while busy");
   busy_silent_a: assert property ($rose(|io_oe) |-> !busy)
      else $error("lanes driven while busy");
   pd_entry_cs_a: assert property ($rose(power_down) |-> cs_n_pin && $past(cs_n_pin, 300))
      else $error("power-down entered without a closed request");
   wake_cs_a: assert property ($fell(power_down) |-> cs_n_pin && $past(cs_n_pin, 200))
      else $error("wake finished while chip select low");
   pd_quiet_a: assert property (power_down |-> (io_oe == 4'h0 || io_oe == 4'h2))
      else $error("wide output while powered down");
   oe_release_a: assert property ($rose(cs_n_pin) |-> ##[1:6] (io_oe == 4'h0))
      else $error("lanes still driven after chip select rose");
   out_after_fall_a: assert property ($changed(io_out) |-> !sclk_pin && !$past(sclk_pin, 2))
      else $error("output changed outside the low clock phase");
endmodule // flash_pd_id_monitor

bind flash_pd_id flash_pd_id_monitor mon_u (
   .core_clk   (core_clk),
   .reset      (reset),
   .sclk_pin   (sclk_pin),
   .cs_n_pin   (cs_n_pin),
   .io_in      (io_in),
   .cycle_busy (cycle_busy),
   .io_out     (io_out),
   .io_oe      (io_oe),
   .power_down (power_down),
   .busy       (busy)
);

// ### verif/flash_pd_id_bench.sv
// Self-checking bench for the power-down and identification handler
`timescale 1ns/10ps
`include "flash_id_defs.vh"
module flash_pd_id_bench;
   reg          core_clk;
   reg          reset;
   reg          cycle_busy;
   wire         sclk;
   wire         cs_n;
   wire [3:0]   host_io;
   wire [3:0]   lane;
   wire [3:0]   io_out;
   wire [3:0]   io_oe;
   wire         power_down;
   wire         busy;
   integer      n_errors;
   integer      cmp_count;

   // Each lane carries whichever party enables it
   assign lane = (io_oe & io_out) | (~io_oe & host_io);

   flash_pd_id dut_u (.core_clk(core_clk), .reset(reset), .sclk_pin(sclk), .cs_n_pin(cs_n),
      .io_in(lane), .cycle_busy(cycle_busy), .io_out(io_out), .io_oe(io_oe),
      .power_down(power_down), .busy(busy));
   spi_host_model host_u (.core_clk(core_clk), .dev_io(lane), .sclk(sclk), .cs_n(cs_n),
      .io(host_io));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------------
   task check(input [63:0] seen, input [63:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   task finish_test;
      begin
         if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   task idle(input integer n);
      repeat (n) @(negedge core_clk);
   endtask

   function [3:0] lm(input integer w);
      lm = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
   endfunction

   // n link clocks of v, w bits per clock, most significant first
   task shift(input [63:0] v, input integer n, input integer w);
      integer k;
      reg [63:0] t;
      reg [3:0] q;
      begin
         for (k = n - 1; k >= 0; k = k - 1) begin
            t = v >> (k * w);
            host_u.pulse(t[3:0] & lm(w), q);
         end
      end
   endtask

   // Host lanes toggle during reads so a stale value never looks like data
   task read(input integer n, input integer w, output [63:0] acc);
      integer k;
      reg [3:0] q;
      begin
         acc = 64'h0;
         for (k = 0; k < n; k = k + 1) begin
            host_u.pulse(k[3:0], q);
            acc = (w == 1) ? {acc[62:0], q[1]} : ((acc << w) | {60'h0, q & lm(w)});
         end
      end
   endtask

   task run(input [7:0] op, input [63:0] pre, input integer pn, input integer pw,
            input integer n, input integer w, input [3:0] oe, input [63:0] exp);
      reg [63:0] got;
      begin
         host_u.open_frame;
         shift({56'h0, op}, 8, 1);
         shift(pre, pn, pw);
         read(n, w, got);
         check(io_oe, oe);
         host_u.close_frame;
         idle(8);
         check(io_oe, 4'h0);
         if (oe != 4'h0) check(got, exp);
      end
   endtask

   task enter_pd(input integer extra);
      begin
         host_u.open_frame;
         shift({56'h0, `OP_POWER_DOWN} << extra, 8 + extra, 1);
         host_u.close_frame;
      end
   endtask

   // Counts core cycles from the chip select rise until the power state flips
   task wait_pd(input exp, input integer lo, input integer hi);
      integer n;
      begin
         n = 0;
         while (power_down !== exp && n <= hi) begin
            @(negedge core_clk);
            n = n + 1;
         end
         check(power_down, exp);
         check(n >= lo && n <= hi, 1'b1);
      end
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task t_identity;
      run(`OP_IDENTITY, 0, 0, 1, 48, 1, 4'h2, {`MFR_CODE, `MEMORY_TYPE, `CAPACITY,
          `MFR_CODE, `MEMORY_TYPE, `CAPACITY});
   endtask
   task t_release_code;
      run(`OP_RELEASE_ID, 0, 24, 1, 24, 1, 4'h2, {3{`DEVICE_CODE}});
   endtask
   task t_mfr_single;
      run(`OP_MFR_DEV, 0, 24, 1, 32, 1, 4'h2, {2{`MFR_CODE, `DEVICE_CODE}});
   endtask
   task t_mfr_dual;
      run(`OP_MFR_DEV_DUAL, 64'hFF, 16, 2, 16, 2, 4'h3, {2{`MFR_CODE, `DEVICE_CODE}});
   endtask
   task t_mfr_quad;
      run(`OP_MFR_DEV_QUAD, 64'hFF_0000, 12, 4, 8, 4, 4'hF, {2{`MFR_CODE, `DEVICE_CODE}});
   endtask
   task t_unique;
      run(`OP_UNIQUE_ID, 0, 32, 1, 64, 1, 4'h2, `UNIQUE_NUMBER);
   endtask
   task t_table;
      run(`OP_TABLE_READ, 64'h0200, 32, 1, 24, 1, 4'h2,
          {`TABLE_SIG2, `TABLE_SIG3, `TABLE_FILL});
   endtask

   task t_power_down;
      begin
         enter_pd(0);
         wait_pd(1'b1, `PD_ENTRY_CYC - 8, `PD_ENTRY_CYC);
         run(`OP_IDENTITY, 0, 0, 1, 24, 1, 4'h0, 0);
         check(power_down, 1'b1);
         host_u.open_frame;
         shift({56'h0, `OP_RELEASE_ID}, 8, 1);
         host_u.close_frame;
         wait_pd(1'b0, `WAKE_CYC - 8, `WAKE_CYC);
         t_identity;
      end
   endtask

   task t_late_cs;
      begin
         enter_pd(1);
         idle(`PD_ENTRY_CYC + 20);
         check(power_down, 1'b0);
      end
   endtask

   task t_pd_code;
      reg [63:0] got;
      begin
         enter_pd(0);
         wait_pd(1'b1, `PD_ENTRY_CYC - 8, `PD_ENTRY_CYC);
         host_u.open_frame;
         shift({56'h0, `OP_RELEASE_ID} << 24, 32, 1);
         read(8, 1, got);
         host_u.close_frame;
         check(got, `DEVICE_CODE);
         wait_pd(1'b0, `WAKE_CODE_CYC - 8, `WAKE_CODE_CYC);
      end
   endtask

   task t_busy;
      begin
         cycle_busy = 1'b1;
         idle(2);
         check(busy, 1'b1);
         run(`OP_RELEASE_ID, 0, 24, 1, 8, 1, 4'h0, 0);
         enter_pd(0);
         idle(`PD_ENTRY_CYC + 20);
         check(power_down, 1'b0);
         cycle_busy = 1'b0;
         idle(2);
         check(busy, 1'b0);
         t_release_code;
      end
   endtask

   initial begin
      n_errors = 0;
      cmp_count = 0;
      reset = 1'b1;
      cycle_busy = 1'b0;
      idle(20);
      reset = 1'b0;
      idle(4);
      check(power_down, 1'b0);
      check(io_oe, 4'h0);
      t_identity;
      t_release_code;
      t_mfr_single;
      t_mfr_dual;
      t_mfr_quad;
      t_unique;
      t_table;
      t_power_down;
      t_late_cs;
      t_pd_code;
      t_busy;
      finish_test;
   end

   // The sequence needs about 130 us; three times that means a hang
   initial begin
      #400000;
      n_errors = n_errors + 1;
      finish_test;
   end
endmodule // flash_pd_id_bench
